// ===== lccu_contact_unit.v
// Ladder contact compare unit: logic and compare contacts joined into the rung
`timescale 1ns/1ns
module lccu_contact_unit (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   input wire clk_en,
   // Instruction request
   input wire req_valid,
   input wire [8:0] opcode,
   input wire wide,
   input wire rung_in,
   // Operand one: low word, high word, or immediate float
   input wire [15:0] s1_lo,
   input wire [15:0] s1_hi,
   input wire s1_imm_sel,
   input wire [31:0] s1_imm,
   // Operand two
   input wire [15:0] s2_lo,
   input wire [15:0] s2_hi,
   input wire s2_imm_sel,
   input wire [31:0] s2_imm,
   // Result
   output reg rung_out_q,
   output reg contact_q,
   output reg done_q,
   output reg illegal_q
);
`include "lccu_map.vh"
   wire is_log;
   wire is_flt;
   wire [1:0] logic_op;
   wire [2:0] rel;
   wire [1:0] join_sel;
   wire legal;

   lccu_decode u_dec (
      .opcode(opcode),
      .is_log(is_log),
      .is_flt(is_flt),
      .logic_op(logic_op),
      .rel(rel),
      .join_sel(join_sel),
      .legal(legal)
   );

   // Operand ports gathered so both operands share one generate body
   localparam OPND_N = 2;
   wire [15:0] lo_word [0:OPND_N-1];
   wire [15:0] hi_word [0:OPND_N-1];
   wire [31:0] imm_word [0:OPND_N-1];
   wire imm_pick [0:OPND_N-1];
   wire [31:0] opnd_ext [0:OPND_N-1];
   wire [31:0] opnd_reg [0:OPND_N-1];
   wire [31:0] opnd [0:OPND_N-1];
   wire [`LCCU_FP_EXP_HI-`LCCU_FP_EXP_LO:0] opnd_exp [0:OPND_N-1];
   wire [`LCCU_FP_MANT_HI:0] opnd_mant [0:OPND_N-1];
   wire [`LCCU_FP_MAG_HI:0] opnd_mag [0:OPND_N-1];
   wire opnd_sign [0:OPND_N-1];
   wire opnd_nan [0:OPND_N-1];
   wire opnd_zero [0:OPND_N-1];
   assign lo_word[0] = s1_lo;
   assign lo_word[1] = s2_lo;
   assign hi_word[0] = s1_hi;
   assign hi_word[1] = s2_hi;
   assign imm_word[0] = s1_imm;
   assign imm_word[1] = s2_imm;
   assign imm_pick[0] = s1_imm_sel;
   assign imm_pick[1] = s2_imm_sel;

   // Float codes are always 32-bit, whatever the wide input says
   wire use_wide = wide | is_flt;

   genvar gi;
   generate
      for (gi = 0; gi < OPND_N; gi = gi + 1) begin : g_opnd
         assign opnd_ext[gi] =
            {{(`LCCU_WORD_HI + 1){lo_word[gi][`LCCU_SIGN16]}}, lo_word[gi]};
         // Second register of the pair holds the upper word
         assign opnd_reg[gi] = use_wide ? {hi_word[gi], lo_word[gi]} : opnd_ext[gi];
         assign opnd[gi] = (is_flt && imm_pick[gi]) ? imm_word[gi] : opnd_reg[gi];
         assign opnd_exp[gi] = opnd[gi][`LCCU_FP_EXP_HI:`LCCU_FP_EXP_LO];
         assign opnd_mant[gi] = opnd[gi][`LCCU_FP_MANT_HI:0];
         assign opnd_mag[gi] = opnd[gi][`LCCU_FP_MAG_HI:0];
         assign opnd_sign[gi] = opnd[gi][`LCCU_FP_SIGN];
         // Single-precision specials: NaN and either signed zero
         assign opnd_nan[gi] = (opnd_exp[gi] == `LCCU_FP_EXP_MAX) &&
            (opnd_mant[gi] != 23'h000000);
         assign opnd_zero[gi] = (opnd_mag[gi] == 31'h00000000);
      end
   endgenerate

   wire [31:0] a = opnd[0];
   wire [31:0] b = opnd[1];

   reg [31:0] bitres;
   always @* begin
      case (logic_op)
         `LCCU_LOG_OR: bitres = a | b;
         `LCCU_LOG_XOR: bitres = a ^ b;
         default: bitres = a & b;
      endcase
   end
   wire log_hit = (bitres != `LCCU_ZERO32);

   // Signed integer ordering
   wire int_lt = $signed(a) < $signed(b);
   wire int_eq = (a == b);

   // Single-precision ordering; signed zeros equal, NaN unordered
   wire unord = opnd_nan[0] | opnd_nan[1];
   wire both_zero = opnd_zero[0] && opnd_zero[1];
   wire sa = opnd_sign[0];
   wire sb = opnd_sign[1];
   wire mag_lt = opnd_mag[0] < opnd_mag[1];
   wire mag_gt = opnd_mag[0] > opnd_mag[1];
   wire f_eq = !unord && (both_zero || a == b);
   wire f_lt = !unord && !both_zero &&
      ((sa && !sb) || (!sa && !sb && mag_lt) || (sa && sb && mag_gt));

   wire eq = is_flt ? f_eq : int_eq;
   wire lt = is_flt ? f_lt : int_lt;
   // Unordered floats fail every relation except unequal
   wire f_gt = !unord && !f_eq && !f_lt;
   wire int_gt = !int_eq && !int_lt;
   wire gt = is_flt ? f_gt : int_gt;

   reg cmp_hit;
   always @* begin
      case (rel)
         `LCCU_REL_GT: cmp_hit = gt;
         `LCCU_REL_LT: cmp_hit = lt;
         `LCCU_REL_NE: cmp_hit = !eq;
         `LCCU_REL_LE: cmp_hit = lt | eq;
         `LCCU_REL_GE: cmp_hit = gt | eq;
         default: cmp_hit = eq;
      endcase
   end

   wire hit = is_log ? log_hit : cmp_hit;
   reg rung_join;
   always @* begin
      case (join_sel)
         `LCCU_JOIN_SER: rung_join = rung_in & hit;
         `LCCU_JOIN_PAR: rung_join = rung_in | hit;
         default: rung_join = hit;
      endcase
   end

   // Illegal codes leave rung and contact untouched, so the rung survives a bad fetch
   reg rung_d;
   reg contact_d;
   reg done_d;
   reg illegal_d;
   always @* begin
      rung_d = rung_out_q;
      contact_d = contact_q;
      done_d = req_valid;
      illegal_d = illegal_q;
      if (req_valid) begin
         illegal_d = !legal;
         if (legal) begin
            rung_d = rung_join;
            contact_d = hit;
         end
      end
   end

   // Clock enable low freezes every flop, the done pulse included
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rung_out_q <= 1'b0;
         contact_q <= 1'b0;
         done_q <= 1'b0;
         illegal_q <= 1'b0;
      end else if (clk_en) begin
         rung_out_q <= rung_d;
         contact_q <= contact_d;
         done_q <= done_d;
         illegal_q <= illegal_d;
      end
   end
endmodule // lccu_contact_unit

// ===== lccu_map.vh
// Opcode, width and field constants for the ladder contact compare unit
`ifndef LCCU_MAP_VH
`define LCCU_MAP_VH
`define LCCU_OP_W 9
`define LCCU_OP_LOG_LD 9'h0D7
`define LCCU_OP_LOG_SER 9'h0DA
`define LCCU_OP_LOG_PAR 9'h0DD
`define LCCU_OP_CMP_LD 9'h0E0
`define LCCU_OP_CMP_SER 9'h0E8
`define LCCU_OP_CMP_PAR 9'h0F0
`define LCCU_OP_FLT_LD 9'h113
`define LCCU_OP_FLT_SER 9'h119
`define LCCU_OP_FLT_PAR 9'h11F
`define LCCU_LOG_SPAN 9'h003
`define LCCU_FLT_SPAN 9'h006
`define LCCU_CMP_SPAN 9'h007
`define LCCU_CMP_HOLE 3'h3
`define LCCU_REL_EQ 3'h0
`define LCCU_REL_GT 3'h1
`define LCCU_REL_LT 3'h2
`define LCCU_REL_NE 3'h3
`define LCCU_REL_LE 3'h4
`define LCCU_REL_GE 3'h5
`define LCCU_LOG_AND 2'h0
`define LCCU_LOG_OR 2'h1
`define LCCU_LOG_XOR 2'h2
`define LCCU_JOIN_LD 2'h0
`define LCCU_JOIN_SER 2'h1
`define LCCU_JOIN_PAR 2'h2
`define LCCU_FP_SIGN 31
`define LCCU_FP_EXP_HI 30
`define LCCU_FP_EXP_LO 23
`define LCCU_FP_EXP_MAX 8'hFF
`define LCCU_FP_MANT_HI 22
`define LCCU_FP_MAG_HI 30
`define LCCU_WORD_HI 15
`define LCCU_SIGN16 15
`define LCCU_SIGN32 31
`define LCCU_ZERO32 32'h00000000
`endif

// ===== lccu_decode.v
// Opcode decoder: maps an instruction code to kind, relation and join
`timescale 1ns/1ns
module lccu_decode (
   // Instruction code
   input wire [8:0] opcode,
   // Decoded fields
   output reg is_log,
   output reg is_flt,
   output reg [1:0] logic_op,
   output reg [2:0] rel,
   output reg [1:0] join_sel,
   output reg legal
);
`include "lccu_map.vh"
   reg [8:0] off;
   always @* begin
      is_log = 1'b0;
      is_flt = 1'b0;
      logic_op = `LCCU_LOG_AND;
      rel = `LCCU_REL_EQ;
      join_sel = `LCCU_JOIN_LD;
      legal = 1'b0;
      off = 9'h000;
      if (opcode >= `LCCU_OP_LOG_LD && opcode < `LCCU_OP_CMP_LD) begin
         is_log = 1'b1;
         legal = 1'b1;
         off = opcode - `LCCU_OP_LOG_LD;
         if (off >= `LCCU_LOG_SPAN + `LCCU_LOG_SPAN) begin
            join_sel = `LCCU_JOIN_PAR;
            off = off - (`LCCU_LOG_SPAN + `LCCU_LOG_SPAN);
         end else if (off >= `LCCU_LOG_SPAN) begin
            join_sel = `LCCU_JOIN_SER;
            off = off - `LCCU_LOG_SPAN;
         end
         logic_op = off[1:0];
      end else if (opcode >= `LCCU_OP_CMP_LD && opcode < `LCCU_OP_CMP_PAR + `LCCU_CMP_SPAN) begin
         off = opcode - `LCCU_OP_CMP_LD;
         join_sel = off[4:3];
         rel = (off[2:0] > `LCCU_CMP_HOLE) ? off[2:0] - 3'h1 : off[2:0];
         legal = (off[2:0] != `LCCU_CMP_HOLE) && (off[2:0] != `LCCU_CMP_SPAN);
      end else if (opcode >= `LCCU_OP_FLT_LD && opcode < `LCCU_OP_FLT_PAR + `LCCU_FLT_SPAN) begin
         is_flt = 1'b1;
         legal = 1'b1;
         off = opcode - `LCCU_OP_FLT_LD;
         if (opcode >= `LCCU_OP_FLT_PAR) begin
            join_sel = `LCCU_JOIN_PAR;
            off = opcode - `LCCU_OP_FLT_PAR;
         end else if (opcode >= `LCCU_OP_FLT_SER) begin
            join_sel = `LCCU_JOIN_SER;
            off = opcode - `LCCU_OP_FLT_SER;
         end
         rel = off[2:0];
      end
   end
endmodule // lccu_decode

// ===== lccu_properties.sv
// Port-level checks for the contact compare unit, bound to every instance
`timescale 1ns/1ns
module lccu_properties (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Request
   input wire clk_en,
   input wire req_valid,
   input wire [8:0] opcode,
   input wire wide,
   input wire rung_in,
   input wire [15:0] s1_lo,
   input wire [15:0] s2_lo,
   // Result
   input wire rung_out_q,
   input wire contact_q,
   input wire done_q,
   input wire illegal_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire take = clk_en && req_valid;
   a_done_pulse: assert property (take |=> done_q)
      else $error("done missing after request");
   a_freeze_hold: assert property (!clk_en |=> $stable({rung_out_q, contact_q, done_q}))
      else $error("outputs moved while disabled");
   a_hole_refused: assert property (take && opcode inside {9'h0E3, 9'h0E7, 9'h12C}
      |=> illegal_q && $stable(rung_out_q)) else $error("undefined code accepted");
   a_and_short: assert property (take && opcode == 9'h0D7 && !wide
      |=> contact_q == |($past(s1_lo) & $past(s2_lo))) else $error("and contact wrong");
   a_lt_signed: assert property (take && opcode == 9'h0E2 && !wide
      |=> contact_q == ($signed($past(s1_lo)) < $signed($past(s2_lo)))) else $error("lt wrong");
   a_series_join: assert property (take && opcode inside {[9'h0DA:9'h0DC], [9'h0E8:9'h0EA],
      [9'h0EC:9'h0EE], [9'h119:9'h11E]} |=> rung_out_q == ($past(rung_in) && contact_q))
      else $error("series join wrong");
   a_par_join: assert property (take && opcode inside {[9'h0DD:9'h0DF], [9'h0F0:9'h0F2],
      [9'h0F4:9'h0F6], [9'h11F:9'h124]} |=> rung_out_q == ($past(rung_in) || contact_q))
      else $error("parallel join wrong");
   a_load_join: assert property (take && opcode inside {[9'h0D7:9'h0D9], [9'h0E0:9'h0E2],
      [9'h0E4:9'h0E6], [9'h113:9'h118]} |=> rung_out_q == contact_q) else $error("load wrong");
   cover property (take && opcode == 9'h0E8);
   cover property (take && opcode == 9'h11F);
   cover property (take ##1 illegal_q);
endmodule // lccu_properties
bind lccu_contact_unit lccu_properties u_props (.mclk, .rst_n, .clk_en, .req_valid, .opcode,
   .wide, .rung_in, .s1_lo, .s2_lo, .rung_out_q, .contact_q, .done_q, .illegal_q);

// ===== lccu_opnd_model.sv
// Operand register file model: each operand is a register and its follower
`timescale 1ns/1ns
module lccu_opnd_model (
   // Operand words
   output wire [15:0] s1_lo,
   output wire [15:0] s1_hi,
   output wire [15:0] s2_lo,
   output wire [15:0] s2_hi
);
   reg [15:0] rf [0:3];
   assign s1_lo = rf[0];
   assign s1_hi = rf[1];
   assign s2_lo = rf[2];
   assign s2_hi = rf[3];
endmodule // lccu_opnd_model

// ===== tb_top.sv
// Self-checking bench for the contact compare unit
`timescale 1ns/1ns
module tb_top;
   reg mclk = 1'b0;
   reg rst_n = 1'b0;
   reg clk_en = 1'b1;
   reg req_valid = 1'b0;
   reg [8:0] opcode = 9'h000;
   reg wide = 1'b0;
   reg rung_in = 1'b0;
   reg s1_imm_sel = 1'b0;
   reg s2_imm_sel = 1'b0;
   reg [31:0] s1_imm = 32'h00000000;
   reg [31:0] s2_imm = 32'h00000000;
   wire [15:0] s1_lo, s1_hi, s2_lo, s2_hi;
   wire rung_out_q, contact_q, done_q, illegal_q;
   logic exp_rung = 1'b0;
   int error_cnt = 0;
   int samples_checked = 0;
   lccu_opnd_model PM (.s1_lo(s1_lo), .s1_hi(s1_hi), .s2_lo(s2_lo), .s2_hi(s2_hi));
   lccu_contact_unit DUT (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid),
      .opcode(opcode), .wide(wide), .rung_in(rung_in), .s1_lo(s1_lo), .s1_hi(s1_hi),
      .s1_imm_sel(s1_imm_sel), .s1_imm(s1_imm), .s2_lo(s2_lo), .s2_hi(s2_hi),
      .s2_imm_sel(s2_imm_sel), .s2_imm(s2_imm), .rung_out_q(rung_out_q),
      .contact_q(contact_q), .done_q(done_q), .illegal_q(illegal_q));
   initial forever #25 mclk = ~mclk;
   task automatic chk(input logic seen, input logic exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: code %0d seen %b want %b", $time, opcode, seen, exp);
      end
   endtask
   // Index is the offset inside a block of codes; 3 and 7 are holes
   function automatic logic rel(input int k, input longint a, input longint b);
      case (k)
         0: return a == b;
         1: return a > b;
         2: return a < b;
         4: return a != b;
         5: return a <= b;
         default: return a >= b;
      endcase
   endfunction
   // One-cycle latency is fixed, so the answer is read one edge later
   task automatic req(input logic [8:0] op, input logic c, input int j, input logic ill);
      @(posedge mclk) #5;
      opcode = op;
      rung_in = op[1];
      req_valid = 1'b1;
      @(posedge mclk) #5;
      req_valid = 1'b0;
      if (!ill) exp_rung = j == 0 ? c : j == 1 ? rung_in & c : rung_in | c;
      chk(done_q, 1'b1);
      chk(illegal_q, ill);
      chk(rung_out_q, exp_rung);
      if (!ill) chk(contact_q, c);
   endtask
   task automatic t_logic;
      for (int op = 215; op <= 223; op++) req(9'(op), (op - 215) % 3 != 0, (op - 215) / 3, 1'b0);
      wide = 1'b1;
      req(9'h0D7, 1'b1, 0, 1'b0);
      $display("logic contacts done");
   endtask
   task automatic t_int(input logic w, input longint a, input longint b);
      wide = w;
      for (int op = 224; op <= 246; op++)
         req(9'(op), rel((op - 224) % 8, a, b), (op - 224) / 8, (op - 224) % 8 inside {3, 7});
      req(9'h12C, 1'b0, 0, 1'b1);
      $display("integer compares done");
   endtask
   task automatic t_float;
      s1_imm_sel = 1'b1;
      s1_imm = 32'hC0000000;
      PM.rf[2] = 16'h0000;
      PM.rf[3] = 16'hBF00;
      for (int op = 275; op <= 292; op++)
         req(9'(op), rel((op - 275) % 6 + ((op - 275) % 6 > 2), -20, -5), (op - 275) / 6, 1'b0);
      s1_imm_sel = 1'b0;
      s2_imm_sel = 1'b1;
      s2_imm = 32'hBF000000;
      req(9'h114, 1'b1, 0, 1'b0);
      $display("float compares done");
   endtask
   // Signed zeros match; a NaN operand fails all but unequal
   task automatic t_fspecial;
      s1_imm_sel = 1'b1;
      s2_imm_sel = 1'b1;
      s1_imm = 32'h80000000;
      s2_imm = 32'h00000000;
      req(9'h113, 1'b1, 0, 1'b0);
      req(9'h116, 1'b0, 0, 1'b0);
      s1_imm = 32'h7FC00000;
      for (int op = 275; op <= 280; op++) req(9'(op), op == 278, 0, 1'b0);
      s1_imm_sel = 1'b0;
      s2_imm_sel = 1'b0;
      $display("float special values done");
   endtask
   task automatic t_freeze;
      @(posedge mclk) #5;
      clk_en = 1'b0;
      req_valid = 1'b1;
      @(posedge mclk) #5;
      chk(done_q, 1'b0);
      req_valid = 1'b0;
      clk_en = 1'b1;
      $display("clock enable freeze done");
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      PM.rf[0] = 16'h00F0;
      PM.rf[1] = 16'h8000;
      PM.rf[2] = 16'h000F;
      PM.rf[3] = 16'h8000;
      #105 rst_n = 1'b1;
      t_logic;
      PM.rf[0] = 16'hFFE2;
      PM.rf[1] = 16'h0001;
      PM.rf[2] = 16'h0005;
      PM.rf[3] = 16'h0000;
      t_int(1'b0, -30, 5);
      t_int(1'b1, 131042, 5);
      t_float;
      t_fspecial;
      t_freeze;
      give_verdict;
   end
endmodule // tb_top
